// ==== usmsi_top.sv ====
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module usmsi_top
  import usmsi_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   CLK_I,
  input  wire logic                   RESET_I,
  input  wire logic                   CE_I,
  // Register port
  input  wire logic [usmsi_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [31:0]            WDATA_I,
  input  wire logic                   WR_I,
  input  wire logic                   RD_I,
  output logic [31:0]                 RDATA_O,
  // Mode field and mode decode
  input  wire logic [3:0]             MODE_FIELD_I,
  output usmsi_pkg::usmsi_mode_t      MODE_O,
  output logic                        MODE_RESERVED_O,
  // Command strobes, status sources, modem pins
  input  wire usmsi_pkg::usmsi_cmd_t  CMD_I,
  input  wire usmsi_pkg::usmsi_evt_t  EVT_I,
  input  wire usmsi_pkg::usmsi_modem_t MODEM_I,
  input  wire logic [15:0]            IDLE_TIMEOUT_VALUE_I,
  // Interrupt request
  output logic                        IRQ_O
);
  import usmsi_pkg::*;

  usmsi_state_t st_reg;
  usmsi_state_t st_next;
  logic         set_hit;
  logic         clr_hit;
  logic         mask_rd;
  logic         stat_rd;
  logic [31:0]  wbits;
  logic [3:0]   pin_chg;
  logic         spi_slave;
  logic         err_ev10;

  // Read view of the mask: the alias position mirrors its twin
  function automatic logic [31:0] mask_view(input logic [31:0] m);
    logic [31:0] v;
    v = m & MASK_VALID;
    v[BIT_MAN_ALIAS] = m[BIT_MAN_EN];
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    set_hit   = WR_I && (ADDR_I == OFS_IRQ_SET);
    clr_hit   = WR_I && (ADDR_I == OFS_IRQ_CLR);
    mask_rd   = RD_I && (ADDR_I == OFS_IRQ_MASK);
    stat_rd   = RD_I && (ADDR_I == OFS_STATUS);
    spi_slave = (st_reg.mode == USMSI_SPI_SLAVE);

    // Either manchester position drives the one stored enable
    wbits = WDATA_I;
    wbits[BIT_MAN_EN] = WDATA_I[BIT_MAN_EN] | WDATA_I[BIT_MAN_ALIAS];
    wbits = wbits & MASK_VALID;
    if (set_hit) begin
      st_next.mask = st_reg.mask | wbits;
    end
    if (clr_hit) begin
      st_next.mask = st_reg.mask & ~wbits;
    end

    // Mode decode; reserved codes pass through but are flagged
    st_next.mode = usmsi_mode_t'(MODE_FIELD_I);
    case (MODE_FIELD_I)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hE, 4'hF: begin
        st_next.mode_rsv = 1'b0;
      end
      default: begin
        st_next.mode_rsv = 1'b1;
      end
    endcase

    // Modem pins: two-stage synchroniser, then compare with shown level
    st_next.sync1 = MODEM_I;
    st_next.sync2 = st_reg.sync1;
    pin_chg = st_reg.sync2 ^ st_reg.status[BIT_LVL_HI:BIT_LVL_LO];
    st_next.status[BIT_LVL_HI:BIT_LVL_LO] = st_reg.sync2;
    if (stat_rd) begin
      st_next.status[BIT_CHG_HI:BIT_CHG_LO] = 4'h0;
    end
    // A change in the reading cycle survives the clear
    st_next.status[BIT_CHG_HI:BIT_CHG_LO] =
      st_next.status[BIT_CHG_HI:BIT_CHG_LO] | pin_chg;

    // Negative acknowledge
    if (CMD_I.clear_nak_command) begin
      st_next.status[BIT_NAK] = 1'b0;
    end
    if (EVT_I.nak_seen) begin
      st_next.status[BIT_NAK] = 1'b1;
    end

    st_next.status[BIT_DMA_FULL] = EVT_I.dma_receive_full;

    // Error group: clear first, then any new event sets again
    if (CMD_I.clear_errors_command) begin
      st_next.status = st_next.status & ~ERR_BITS;
    end
    err_ev10 = spi_slave ? EVT_I.slave_underrun : EVT_I.repeat_limit_hit;
    if (err_ev10) begin
      st_next.status[BIT_REPEAT] = 1'b1;
    end
    if (EVT_I.parity_fault || (EVT_I.multidrop && EVT_I.parity_bit_one)) begin
      st_next.status[BIT_PARITY] = 1'b1;
    end
    if (EVT_I.stop_bit_low) begin
      st_next.status[BIT_FRAME] = 1'b1;
    end
    if (EVT_I.overrun_fault) begin
      st_next.status[BIT_OVERRUN] = 1'b1;
    end
    if (EVT_I.break_edge) begin
      st_next.status[BIT_BREAK] = 1'b1;
    end
    if (EVT_I.manchester_fault) begin
      st_next.status[BIT_MAN_FLAG] = 1'b1;
    end

    // Receive timeout: only armed timers with a non-zero value may latch
    if (CMD_I.start_idle_timer_command || CMD_I.rearm_idle_timer_command) begin
      st_next.timer_armed = 1'b1;
      st_next.status[BIT_TIMEOUT] = 1'b0;
    end
    if (EVT_I.idle_expired && st_reg.timer_armed && (IDLE_TIMEOUT_VALUE_I != 16'h0000)) begin
      st_next.status[BIT_TIMEOUT] = 1'b1;
    end

    // Receive ready
    if (EVT_I.receive_holding_read) begin
      st_next.status[BIT_RX_RDY] = 1'b0;
    end
    if (EVT_I.char_received) begin
      st_next.status[BIT_RX_RDY] = 1'b1;
    end

    // Transmitter: disable wins over enable, as the enable is conditional
    if (CMD_I.tx_disable) begin
      st_next.tx_en = 1'b0;
    end else if (CMD_I.tx_enable) begin
      st_next.tx_en = 1'b1;
    end
    if (CMD_I.begin_break_command) begin
      st_next.brk_req = 1'b1;
    end else if (EVT_I.break_done) begin
      st_next.brk_req = 1'b0;
    end
    // Levels, so enabling the transmitter raises them on the next edge
    st_next.status[BIT_TX_RDY] = st_next.tx_en && !EVT_I.thr_pending
                                 && !st_next.brk_req;
    st_next.status[BIT_TX_EMPTY] = st_next.status[BIT_TX_RDY]
                                   && !EVT_I.shift_busy;

    // Read data: one cycle after the strobe, zero otherwise and when unmapped
    st_next.rdata = 32'h00000000;
    if (mask_rd) begin
      st_next.rdata = mask_view(st_reg.mask);
    end
    if (stat_rd) begin
      st_next.rdata = st_reg.status;
    end

    // Taken from the next state so the line agrees with the registers
    st_next.irq = |(st_next.status & mask_view(st_next.mask) & IRQ_SOURCES);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st_reg <= ST_RST;
    end else if (CE_I) begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O         = st_reg.rdata;
  assign IRQ_O           = st_reg.irq;
  assign MODE_O          = st_reg.mode;
  assign MODE_RESERVED_O = st_reg.mode_rsv;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  mask_set_a: assert property (
    (CE_I && set_hit && !clr_hit) |=>
      ((st_reg.mask & $past(wbits)) == $past(wbits)) &&
      ((st_reg.mask & ~$past(wbits)) == ($past(st_reg.mask) & ~$past(wbits))))
    else $error("enable-set write did not set exactly its mask bits");

  mask_clear_a: assert property (
    (CE_I && clr_hit) |=>
      ((st_reg.mask & $past(wbits)) == 32'h00000000) &&
      ((st_reg.mask | $past(wbits)) == ($past(st_reg.mask) | $past(wbits))))
    else $error("enable-clear write did not clear exactly its mask bits");

  man_alias_a: assert property (
    (CE_I && RD_I && ADDR_I == OFS_IRQ_MASK) |=> (RDATA_O[24] == RDATA_O[20]))
    else $error("manchester mask positions read differently");

  mask_reset_a: assert property (disable iff (1'b0)
    RESET_I |=> (st_reg.mask == MASK_RST) && (st_reg.status == STATUS_RST))
    else $error("mask or status not zero after reset");

  pin_level_a: assert property (
    ($past(CE_I, 1) && $past(CE_I, 2) && $past(CE_I, 3) && !$past(RESET_I, 1)
     && !$past(RESET_I, 2) && !$past(RESET_I, 3))
      |-> (st_reg.status[23:20] == $past(MODEM_I, 3)))
    else $error("pin level image does not follow the pins");

  pin_change_a: assert property (
    (CE_I && pin_chg != 4'h0) |=> ((st_reg.status[19:16] & $past(pin_chg)) == $past(pin_chg)))
    else $error("pin change flag lost");

  nak_hold_a: assert property (
    (st_reg.status[BIT_NAK] && !(CE_I && CMD_I.clear_nak_command)) |=> st_reg.status[BIT_NAK])
    else $error("nak flag dropped without its clear command");

  timeout_zero_a: assert property (
    (CE_I && !st_reg.status[BIT_TIMEOUT] && IDLE_TIMEOUT_VALUE_I == 16'h0000)
      |=> !st_reg.status[BIT_TIMEOUT])
    else $error("timeout flag set with zero timeout value");

  tx_order_a: assert property (
    st_reg.status[BIT_TX_EMPTY] |-> (st_reg.status[BIT_TX_RDY] && st_reg.tx_en))
    else $error("transmit empty without transmit ready");

  break_clears_a: assert property (
    (CE_I && CMD_I.begin_break_command) |=>
      (!st_reg.status[BIT_TX_RDY] && !st_reg.status[BIT_TX_EMPTY]))
    else $error("break request left transmit flags set");

  err_clear_a: assert property (
    (CE_I && CMD_I.clear_errors_command && !EVT_I.parity_fault && !EVT_I.parity_bit_one
     && !EVT_I.stop_bit_low && !EVT_I.overrun_fault && !EVT_I.break_edge
     && !EVT_I.manchester_fault && !EVT_I.repeat_limit_hit && !EVT_I.slave_underrun)
      |=> ((st_reg.status & ERR_BITS) == 32'h00000000))
    else $error("error clear left an error flag set");

  irq_line_a: assert property (
    IRQ_O == |(st_reg.status & mask_view(st_reg.mask) & IRQ_SOURCES))
    else $error("request line disagrees with flags and mask");

  mode_decode_a: assert property (
    CE_I |=> (MODE_O == $past(MODE_FIELD_I)) && (MODE_RESERVED_O == !($past(MODE_FIELD_I)
      inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hE, 4'hF})))
    else $error("mode decode disagrees with the mode field");

  dma_follow_a: assert property (
    CE_I |=> (st_reg.status[BIT_DMA_FULL] == $past(EVT_I.dma_receive_full)))
    else $error("dma full flag does not follow its source");

  repeat_latch_a: assert property (
    (CE_I && ((st_reg.mode == USMSI_SPI_SLAVE) ? EVT_I.slave_underrun : EVT_I.repeat_limit_hit))
      |=> st_reg.status[BIT_REPEAT])
    else $error("repeat limit or underrun not latched");

  repeat_mode_a: assert property (
    (CE_I && !st_reg.status[BIT_REPEAT] && ((st_reg.mode == USMSI_SPI_SLAVE) ?
      !EVT_I.slave_underrun : !EVT_I.repeat_limit_hit)) |=> !st_reg.status[BIT_REPEAT])
    else $error("repeat flag set by the event of the other mode");

  parity_latch_a: assert property (
    (CE_I && (EVT_I.parity_fault || (EVT_I.multidrop && EVT_I.parity_bit_one)))
      |=> st_reg.status[BIT_PARITY])
    else $error("parity event not latched");

  frame_latch_a: assert property (
    (CE_I && EVT_I.stop_bit_low) |=> st_reg.status[BIT_FRAME])
    else $error("low stop bit not latched");

  overrun_latch_a: assert property (
    (CE_I && EVT_I.overrun_fault) |=> st_reg.status[BIT_OVERRUN])
    else $error("receive overrun not latched");

  break_latch_a: assert property (
    (CE_I && EVT_I.break_edge) |=> st_reg.status[BIT_BREAK])
    else $error("break edge not latched");

  man_flag_a: assert property (
    (CE_I && EVT_I.manchester_fault) |=> st_reg.status[BIT_MAN_FLAG])
    else $error("manchester error not latched");

  err_hold_a: assert property (
    (CE_I && !CMD_I.clear_errors_command)
      |=> (($past(st_reg.status) & ERR_BITS & ~st_reg.status) == 32'h00000000))
    else $error("error flag dropped without the error clear command");

  rx_set_a: assert property (
    (CE_I && EVT_I.char_received) |=> st_reg.status[BIT_RX_RDY])
    else $error("received character did not raise receive ready");

  rx_clear_a: assert property (
    (CE_I && EVT_I.receive_holding_read && !EVT_I.char_received)
      |=> !st_reg.status[BIT_RX_RDY])
    else $error("holding read did not clear receive ready");

  timeout_clear_a: assert property (
    (CE_I && (CMD_I.start_idle_timer_command || CMD_I.rearm_idle_timer_command)
     && !EVT_I.idle_expired) |=> !st_reg.status[BIT_TIMEOUT])
    else $error("start or rearm command left the timeout flag set");

  tx_off_a: assert property (
    (CE_I && CMD_I.tx_disable) |=>
      (!st_reg.status[BIT_TX_RDY] && !st_reg.status[BIT_TX_EMPTY]))
    else $error("disabled transmitter shows ready or empty");

  tx_on_a: assert property (
    (CE_I && CMD_I.tx_enable && !CMD_I.tx_disable && !CMD_I.begin_break_command
     && !st_reg.brk_req && !EVT_I.thr_pending) |=> st_reg.status[BIT_TX_RDY])
    else $error("enabled idle transmitter not ready");

  overrun_cov: cover property (CE_I && EVT_I.overrun_fault ##1 st_reg.status[BIT_OVERRUN]);
  irq_cov:     cover property (!IRQ_O ##1 IRQ_O);
  chg_rd_cov:  cover property (st_reg.status[BIT_CHG_LO] ##1 (CE_I && stat_rd));
  slave_cov:   cover property (spi_slave && CE_I && EVT_I.slave_underrun);
  nak_clr_cov: cover property (st_reg.status[BIT_NAK] ##1 (CE_I && CMD_I.clear_nak_command));

endmodule

// ==== usmsi_pkg.sv ====
package usmsi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_IRQ_SET  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_CLR  = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0]  OFS_STATUS   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions of the status and mask words
  // ----------------------------------------------------------------
  localparam int unsigned BIT_RX_RDY    = 0;
  localparam int unsigned BIT_TX_RDY    = 1;
  localparam int unsigned BIT_BREAK     = 2;
  localparam int unsigned BIT_OVERRUN   = 5;
  localparam int unsigned BIT_FRAME     = 6;
  localparam int unsigned BIT_PARITY    = 7;
  localparam int unsigned BIT_TIMEOUT   = 8;
  localparam int unsigned BIT_TX_EMPTY  = 9;
  localparam int unsigned BIT_REPEAT    = 10;
  localparam int unsigned BIT_DMA_FULL  = 12;
  localparam int unsigned BIT_NAK       = 13;
  localparam int unsigned BIT_CHG_LO    = 16;
  localparam int unsigned BIT_CHG_HI    = 19;
  localparam int unsigned BIT_LVL_LO    = 20;
  localparam int unsigned BIT_LVL_HI    = 23;
  localparam int unsigned BIT_MAN_EN    = 20;
  localparam int unsigned BIT_MAN_ALIAS = 24;
  localparam int unsigned BIT_MAN_FLAG  = 24;

  // Mask bits that exist in storage (alias folded onto its twin)
  localparam logic [31:0] MASK_VALID  = 32'h001F37E7;
  // Status bits that may raise the request line (pin levels excluded)
  localparam logic [31:0] IRQ_SOURCES = 32'h010F37E7;
  // Status bits cleared together by the error clear command
  localparam logic [31:0] ERR_BITS    = 32'h010004E4;

  localparam logic [31:0] MASK_RST    = 32'h00000000;
  localparam logic [31:0] STATUS_RST  = 32'h00000000;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    USMSI_NORMAL     = 4'h0,
    USMSI_RS485      = 4'h1,
    USMSI_HANDSHAKE  = 4'h2,
    USMSI_MODEM      = 4'h3,
    USMSI_ISO_T0     = 4'h4,
    USMSI_ISO_T1     = 4'h6,
    USMSI_IRDA       = 4'h8,
    USMSI_SPI_MASTER = 4'hE,
    USMSI_SPI_SLAVE  = 4'hF
  } usmsi_mode_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cts;
    logic dcd;
    logic dsr;
    logic ri;
  } usmsi_modem_t;

  typedef struct packed {
    logic clear_nak_command;
    logic clear_errors_command;
    logic start_idle_timer_command;
    logic rearm_idle_timer_command;
    logic begin_break_command;
    logic tx_enable;
    logic tx_disable;
  } usmsi_cmd_t;

  typedef struct packed {
    logic nak_seen;
    logic repeat_limit_hit;
    logic slave_underrun;
    logic idle_expired;
    logic parity_fault;
    logic parity_bit_one;
    logic multidrop;
    logic stop_bit_low;
    logic overrun_fault;
    logic break_edge;
    logic manchester_fault;
    logic char_received;
    logic receive_holding_read;
    logic break_done;
    logic dma_receive_full;
    logic thr_pending;
    logic shift_busy;
  } usmsi_evt_t;

  typedef struct packed {
    logic [31:0]  mask;
    logic [31:0]  status;
    logic [31:0]  rdata;
    usmsi_modem_t sync1;
    usmsi_modem_t sync2;
    logic         tx_en;
    logic         brk_req;
    logic         timer_armed;
    logic         irq;
    usmsi_mode_t  mode;
    logic         mode_rsv;
  } usmsi_state_t;

  localparam usmsi_state_t ST_RST = '0;

endpackage

// ==== usmsi_modem_peer.sv ====
`timescale 1ns/100ps
module usmsi_modem_peer
(
  // Clock
  input  wire logic                    CLK_I,
  // Modem pins toward the device
  output usmsi_pkg::usmsi_modem_t      MODEM_O
);
  import usmsi_pkg::*;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  usmsi_modem_t pins_reg = '0;

  assign MODEM_O = pins_reg;

  // Pins move right after an edge, unrelated to any bus cycle
  task automatic drive(input usmsi_modem_t v);
    @(posedge CLK_I);
    pins_reg <= v;
  endtask
endmodule

// ==== tb_usmsi_mode_status_irq.sv ====
`timescale 1ns/100ps
module tb_usmsi_mode_status_irq;
  import usmsi_pkg::*;

  // ----------------------------------------------------------------
  // Signals and models
  // ----------------------------------------------------------------
  logic         clk    = 1'b0;
  logic         rst    = 1'b1;
  logic         ce     = 1'b1;
  logic [7:0]   addr   = '0;
  logic [31:0]  wdata  = '0;
  logic         wr     = 1'b0;
  logic         rd     = 1'b0;
  logic [3:0]   mode_f = '0;
  usmsi_cmd_t   cmd    = '0;
  usmsi_evt_t   evt    = '0;
  usmsi_evt_t   lvl    = '0;
  logic [15:0]  tov    = '0;
  usmsi_modem_t pins;
  usmsi_mode_t  mode_o;
  logic [31:0]  rdata;
  logic         mode_rsv;
  logic         irq;
  int           err_total = 0;
  int           cmp_count = 0;
  logic [31:0]  m    = '0;
  logic [31:0]  st   = '0;
  logic [31:0]  seed = 32'h48;
  logic [31:0]  d;
  usmsi_evt_t   e;
  int           b;

  always #4 clk = ~clk;

  usmsi_top i_dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MODE_FIELD_I(mode_f), .MODE_O(mode_o),
    .MODE_RESERVED_O(mode_rsv), .CMD_I(cmd), .EVT_I(evt), .MODEM_I(pins),
    .IDLE_TIMEOUT_VALUE_I(tov), .IRQ_O(irq));
  usmsi_modem_peer i_peer (.CLK_I(clk), .MODEM_O(pins));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Manchester enable is stored once and shows at both places
  function automatic logic [31:0] fold(input logic [31:0] v);
    return (v & MASK_VALID) | (32'(v[24]) << 20);
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    cmp_count++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pe(input usmsi_evt_t p);
    @(posedge clk);
    evt <= lvl | p;
    @(posedge clk);
    evt <= lvl;
  endtask
  task automatic pc(input usmsi_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask
  // Request line is judged before the read, which clears the change flags
  task automatic cs(input string n);
    #1 chk({n, " irq"}, 32'(|(st & IRQ_SOURCES & (m | (32'(m[20]) << 24)))), 32'(irq));
    br(OFS_STATUS, d);
    chk(n, st, d);
    st[19:16] = 4'h0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    br(OFS_IRQ_MASK, d);
    chk("mask rst", 32'h00000000, d);
    cs("status rst");
    br(8'h04, d);
    chk("unmapped", 32'h00000000, d);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      bw(i[0] ? OFS_IRQ_CLR : OFS_IRQ_SET, seed);
      m = i[0] ? (m & ~fold(seed)) : (m | fold(seed));
      br(OFS_IRQ_MASK, d);
      chk("mask", m | (32'(m[20]) << 24), d);
    end
    @(posedge clk);
    ce <= 1'b0;
    bw(OFS_IRQ_SET, 32'hFFFFFFFF);
    ce <= 1'b1;
    bw(OFS_IRQ_MASK, 32'hFFFFFFFF);
    br(OFS_IRQ_MASK, d);
    chk("mask held", m | (32'(m[20]) << 24), d);
    bw(OFS_IRQ_SET, 32'hFFFFFFFF);
    m = fold(32'hFFFFFFFF);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      mode_f <= 4'(i);
      repeat (2) @(posedge clk);
      #1 chk("mode rsv", 32'(!(i inside {0, 1, 2, 3, 4, 6, 8, 14, 15})), 32'(mode_rsv));
      if (i inside {0, 1, 2, 3, 4, 6, 8, 14, 15}) chk("mode", i, 32'(mode_o));
    end
    pe('{repeat_limit_hit: 1'b1, default: 1'b0});
    cs("slave repeat");
    pe('{slave_underrun: 1'b1, default: 1'b0});
    st[10] = 1'b1;
    cs("underrun");
    pc('{clear_errors_command: 1'b1, default: 1'b0});
    st[10] = 1'b0;
    cs("underrun clr");
    @(posedge clk);
    mode_f <= 4'h0;
    for (int k = 0; k < 7; k++) begin
      e = '0;
      case (k)
        0: begin e.overrun_fault = 1'b1; b = 5; end
        1: begin e.parity_fault = 1'b1; b = 7; end
        2: begin e.stop_bit_low = 1'b1; b = 6; end
        3: begin e.break_edge = 1'b1; b = 2; end
        4: begin e.manchester_fault = 1'b1; b = 24; end
        5: begin e.repeat_limit_hit = 1'b1; b = 10; end
        default: begin e.nak_seen = 1'b1; b = 13; end
      endcase
      pe(e);
      st[b] = 1'b1;
      cs("err set");
    end
    pc('{clear_errors_command: 1'b1, default: 1'b0});
    st = st & ~32'h010004E4;
    cs("err clr");
    pc('{clear_nak_command: 1'b1, default: 1'b0});
    st[13] = 1'b0;
    cs("nak clr");
    pe('{parity_bit_one: 1'b1, default: 1'b0});
    cs("parity one");
    pe('{parity_bit_one: 1'b1, multidrop: 1'b1, default: 1'b0});
    st[7] = 1'b1;
    cs("multidrop");
    lvl.dma_receive_full = 1'b1;
    pe('0);
    st[12] = 1'b1;
    cs("dma full");
    lvl.dma_receive_full = 1'b0;
    pe('0);
    st[12] = 1'b0;
    cs("dma idle");
    pe('{idle_expired: 1'b1, default: 1'b0});
    cs("unarmed");
    @(posedge clk);
    tov <= 16'h0005;
    pc('{start_idle_timer_command: 1'b1, default: 1'b0});
    pe('{idle_expired: 1'b1, default: 1'b0});
    st[8] = 1'b1;
    cs("timeout");
    pc('{rearm_idle_timer_command: 1'b1, default: 1'b0});
    st[8] = 1'b0;
    cs("rearm");
    @(posedge clk);
    tov <= 16'h0000;
    pe('{idle_expired: 1'b1, default: 1'b0});
    cs("zero value");
    pe('{char_received: 1'b1, default: 1'b0});
    st[0] = 1'b1;
    cs("rx ready");
    pe('{receive_holding_read: 1'b1, default: 1'b0});
    st[0] = 1'b0;
    cs("rx read");
    pc('{tx_enable: 1'b1, default: 1'b0});
    st[1] = 1'b1;
    st[9] = 1'b1;
    cs("tx on");
    lvl.thr_pending = 1'b1;
    pe('0);
    st[1] = 1'b0;
    st[9] = 1'b0;
    cs("thr busy");
    lvl.thr_pending = 1'b0;
    lvl.shift_busy = 1'b1;
    pe('0);
    st[1] = 1'b1;
    cs("shift busy");
    lvl.shift_busy = 1'b0;
    pc('{begin_break_command: 1'b1, default: 1'b0});
    st[1] = 1'b0;
    cs("break req");
    pe('{break_done: 1'b1, default: 1'b0});
    st[1] = 1'b1;
    st[9] = 1'b1;
    cs("break done");
    pc('{tx_disable: 1'b1, default: 1'b0});
    st[1] = 1'b0;
    st[9] = 1'b0;
    cs("tx off");
    for (int j = 0; j < 6; j++) begin
      seed = lfsr(seed);
      i_peer.drive(usmsi_modem_t'(seed[3:0]));
      st[19:16] = st[23:20] ^ seed[3:0];
      st[23:20] = seed[3:0];
      repeat (5) @(posedge clk);
      cs("modem");
    end
    cs("modem quiet");
    bw(OFS_IRQ_CLR, 32'hFFFFFFFF);
    m = '0;
    pe('{overrun_fault: 1'b1, default: 1'b0});
    st[5] = 1'b1;
    cs("masked");
    bw(OFS_IRQ_SET, 32'h00000020);
    m[5] = 1'b1;
    cs("unmasked");
    finish_test();
  end
endmodule
